// [core/rxmc_tick_div.sv]
/*
  divider giving the slow-rc rate as a one-cycle enable pulse.
  assumes the system clock and a synchronous active-high reset.
*/
`default_nettype none
module rxmc_tick_div
  import rxmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  rxmc_tick_if.src t
);
  logic [7:0] cnt_ff; // divide counter
  logic [7:0] nxt_cnt;
  logic tick_ff; // registered pulse
  logic nxt_tick;

  // count down while running, pulse on wrap
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!t.run) begin
      nxt_cnt = 8'(SRC_DIV - 1);
    end else if (cnt_ff == 8'h00) begin
      nxt_cnt = 8'(SRC_DIV - 1);
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  // register only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign t.tick = tick_ff;
endmodule : rxmc_tick_div
`default_nettype wire

// [core/rxmc_top.sv]
/*
  operating mode controller: off, power-up, config copy, standby,
  receive, periodic scan and tune-and-check, with supply/osc enables,
  config shadow in sram, receive buffer and host notification.
  assumes all inputs synchronous to i_clk; host command is a one-cycle
  strobe already decoded from the serial link.
*/
`default_nettype none
module rxmc_top
  import rxmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wake_request_high_pin,
  input wire logic [5:0] i_wake_request_low_pins_n,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd,
  input wire logic i_nv_we,
  input wire logic [3:0] i_nv_addr,
  input wire logic [7:0] i_nv_wdata,
  input wire logic i_sram_we,
  input wire logic i_sram_re,
  input wire logic [3:0] i_sram_addr,
  input wire logic [7:0] i_sram_wdata,
  input wire logic i_buf_rd,
  input wire logic i_preamble_ok,
  input wire logic i_checks_ok,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_nv_we_refused,
  output logic [7:0] o_sram_rdata,
  output logic [7:0] o_buf_rdata,
  output logic o_buf_empty,
  output logic o_notify_port_bit,
  output logic o_digital_supply_domain,
  output logic o_analog_supply_domain,
  output logic o_antenna_switch_supply,
  output logic o_crystal_oscillator,
  output logic o_slow_rc_oscillator,
  output logic o_fast_rc_oscillator,
  output logic [1:0] o_cpu_sleep,
  output logic o_blocks_prog,
  output logic [2:0] o_channel,
  output logic [3:0] o_state,
  output logic o_wake_bias
);
  // config word 0 fields in the shadow
  localparam int F_START = 0; // bits 1:0 start-up selection
  localparam int F_XTAL = 2; // crystal standby variant
  localparam int F_TINIT = 3; // tune at init
  localparam int F_TPER = 4; // periodic tune during scan
  localparam int F_SLP = 5; // bits 6:5 processor sleep mode

  rxmc_state_e st_ff, nxt_st;
  logic [15:0] cnt_ff, nxt_cnt; // state timer
  logic [2:0] ch_ff, nxt_ch; // scan channel
  logic hit_ff, nxt_hit; // telegram found this listen; also set to resume scan after periodic tune
  logic [7:0] nv_mem [CFG_WORDS]; // nonvolatile store model
  logic [7:0] sram_ff [CFG_WORDS]; // fast shadow
  logic [7:0] buf_mem [RXBUF_DEPTH]; // receive buffer
  logic [5:0] wr_ff, rd_ff; // buffer pointers
  logic [5:0] nxt_wr, nxt_rd;
  logic notify_ff, nxt_notify;
  logic refused_ff, nxt_refused;
  logic [7:0] rdat_ff, bdat_ff;
  logic [6:0] outs_ff, nxt_outs; // dv, av, sw, xt, src, frc, prog
  logic [1:0] slp_ff, nxt_slp;
  logic empty_ff, nxt_empty; // registered buffer-empty flag
  logic bias_ff; // wake pin bias enable
  logic wake, cmd_ok, buf_push, buf_pop;
  logic [7:0] cfg0, cfg_sleep, cfg_expect;
  logic [5:0] fill;
  rxmc_tick_if tk();

  rxmc_tick_div u_div (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .t(tk)
  );

  // parameters read from the shadow, except start-up and init-tune bits taken from the slow store
  assign cfg0 = sram_ff[0];
  assign cfg_sleep = sram_ff[1]; // sleep ticks, zero means one
  assign cfg_expect = sram_ff[2]; // expected bytes per telegram
  assign fill = wr_ff - rd_ff;
  assign wake = i_wake_request_high_pin | ~&i_wake_request_low_pins_n;
  // commands dead while off or sequencing
  assign cmd_ok = i_cmd_valid && st_ff != ST_OFF && st_ff != ST_PWRUP;
  // keep bytes only after preamble with checks passing
  assign buf_push = st_ff == ST_RX && i_preamble_ok && i_checks_ok &&
    i_byte_valid && fill != 6'(RXBUF_DEPTH);
  // bytes leave only on host read, or all at once when off clears the pointers
  assign buf_pop = i_buf_rd && fill != 6'h00;
  assign tk.run = st_ff == ST_SCAN_SLEEP || st_ff == ST_SCAN_ACT;

  // main sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ch = ch_ff;
    nxt_hit = hit_ff;
    case (st_ff)
      ST_OFF: begin
        if (wake) begin
          nxt_st = ST_PWRUP;
          nxt_cnt = 16'(PWRUP_CYC - 1);
        end
      end
      ST_PWRUP: begin
        if (cnt_ff == 16'h0000) begin
          nxt_st = ST_CFGCOPY;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      // one word per cycle into sram
      ST_CFGCOPY: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == 16'(CFG_WORDS - 1)) begin
          nxt_cnt = {8'h00, TUNE_CYC};
          nxt_st = nv_mem[0][F_TINIT] ? ST_INITTUNE : ST_STANDBY;
        end
      end
      // tune during init, then start-up choice
      ST_INITTUNE: begin
        if (cnt_ff == 16'h0000) begin
          nxt_st = ST_STANDBY;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      ST_STANDBY: begin
        if (cmd_ok) begin
          case (i_cmd)
            CMD_RX: nxt_st = ST_RXPROG;
            CMD_SCAN: nxt_st = ST_SCAN_ACT;
            CMD_TUNE: nxt_st = ST_TUNE;
            CMD_OFF: nxt_st = ST_OFF;
            default: nxt_st = ST_STANDBY;
          endcase
          // only tune preloads; scan must count its ticks from zero
          nxt_cnt = (i_cmd == CMD_TUNE) ? {8'h00, TUNE_CYC} : 16'h0000;
          nxt_ch = 3'h0;
          nxt_hit = 1'b0;
        end
      end
      ST_RXPROG: nxt_st = ST_RX;
      ST_RX: begin
        if (cmd_ok && i_cmd == CMD_IDLE) begin
          nxt_st = ST_STANDBY;
        end else if (hit_ff && notify_ff) begin
          nxt_st = ST_SCAN_SLEEP;
          nxt_hit = 1'b0;
          nxt_cnt = {8'h00, cfg_sleep};
        end
      end
      ST_SCAN_ACT: begin
        if (cmd_ok && i_cmd == CMD_IDLE) begin
          nxt_st = ST_STANDBY;
        end else if (i_preamble_ok && i_checks_ok) begin
          nxt_st = ST_RXPROG;
          nxt_hit = 1'b1;
        end else if (tk.tick) begin
          // count runs 0 .. ticks-1, so the listen is exactly that long
          if (cnt_ff[7:0] == SCAN_ACTIVE_TICKS - 8'h01) begin
            nxt_cnt = 16'h0000;
            if (ch_ff == 3'(NUM_CH - 1)) begin
              nxt_ch = 3'h0;
              nxt_st = ST_SCAN_SLEEP;
              nxt_cnt = {8'h00, cfg_sleep};
            end else begin
              nxt_ch = ch_ff + 3'h1;
            end
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
      end
      ST_SCAN_SLEEP: begin
        if (cmd_ok && i_cmd == CMD_IDLE) begin
          nxt_st = ST_STANDBY;
        end else if (tk.tick) begin
          if (cnt_ff[7:0] <= 8'h01) begin
            nxt_st = cfg0[F_TPER] ? ST_TUNE : ST_SCAN_ACT;
            nxt_cnt = cfg0[F_TPER] ? {8'h00, TUNE_CYC} : 16'h0000;
            nxt_hit = cfg0[F_TPER];
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
      ST_TUNE: begin
        if (cnt_ff == 16'h0000) begin
          nxt_st = hit_ff ? ST_SCAN_ACT : ST_STANDBY;
          nxt_hit = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: nxt_st = ST_OFF;
    endcase
    if ((st_ff == ST_INITTUNE && cnt_ff == 16'h0000) ||
        (st_ff == ST_CFGCOPY && cnt_ff == 16'(CFG_WORDS - 1) &&
         !nv_mem[0][F_TINIT])) begin
      case (nv_mem[0][F_START+1:F_START])
        START_RX: nxt_st = ST_RXPROG;
        START_SCAN: nxt_st = ST_SCAN_ACT;
        default: nxt_st = ST_STANDBY;
      endcase
      nxt_cnt = 16'h0000;
      nxt_ch = 3'h0;
    end
  end

  // buffer pointers and notification
  always_comb begin
    nxt_wr = wr_ff + (buf_push ? 6'h01 : 6'h00);
    nxt_rd = rd_ff + (buf_pop ? 6'h01 : 6'h00);
    nxt_notify = notify_ff;
    // raise once expected count reached; set wins
    if (fill >= cfg_expect[5:0] && cfg_expect != 8'h00 &&
        st_ff == ST_RX) begin
      nxt_notify = 1'b1;
    end else if (nxt_wr == nxt_rd) begin
      nxt_notify = 1'b0;
    end
    if (st_ff == ST_OFF) begin
      nxt_wr = 6'h00;
      nxt_rd = 6'h00;
      nxt_notify = 1'b0;
    end
    // empty flag follows the next pointers, so it stays in step
    nxt_empty = nxt_wr == nxt_rd;
    nxt_refused = i_nv_we && st_ff != ST_STANDBY;
  end

  always_comb begin
    nxt_slp = SLP_ACTIVE;
    case (nxt_st)
      ST_OFF: nxt_outs = 7'h00;
      ST_PWRUP, ST_CFGCOPY: nxt_outs = 7'b1000110;
      ST_STANDBY: begin
        nxt_outs = cfg0[F_XTAL] ? 7'b1101100 : 7'b1000100;
        nxt_slp = cfg0[F_SLP+1:F_SLP];
      end
      ST_RXPROG: nxt_outs = 7'b1101101;
      ST_RX: nxt_outs = 7'b1101100;
      ST_SCAN_ACT: nxt_outs = 7'b1101110;
      ST_SCAN_SLEEP: begin
        nxt_outs = cfg0[F_XTAL] ? 7'b1101100 : 7'b1000100;
        nxt_slp = cfg0[F_SLP+1:F_SLP];
      end
      ST_TUNE, ST_INITTUNE: nxt_outs = 7'b1101110;
      default: nxt_outs = 7'h00;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= ST_OFF;
      cnt_ff <= 16'h0000;
      ch_ff <= 3'h0;
      hit_ff <= 1'b0;
      wr_ff <= 6'h00;
      rd_ff <= 6'h00;
      notify_ff <= 1'b0;
      refused_ff <= 1'b0;
      outs_ff <= 7'h00;
      slp_ff <= SLP_ACTIVE;
      rdat_ff <= 8'h00;
      bdat_ff <= 8'h00;
      empty_ff <= 1'b1;
      bias_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ch_ff <= nxt_ch;
      hit_ff <= nxt_hit;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      notify_ff <= nxt_notify;
      refused_ff <= nxt_refused;
      outs_ff <= nxt_outs;
      slp_ff <= nxt_slp;
      empty_ff <= nxt_empty;
      bias_ff <= 1'b1;
      if (i_sram_re && cmd_ok == 1'b0 && st_ff != ST_OFF) begin
        rdat_ff <= sram_ff[i_sram_addr];
      end
      if (buf_pop) begin
        bdat_ff <= buf_mem[rd_ff[4:0]];
      end
    end
  end

  // memories; only the store is cleared, to a blank delivered setup,
  // since an unwritten store would leave the start-up choice unknown
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < CFG_WORDS; k++) begin
        nv_mem[k] <= 8'h00;
      end
    end else if (i_nv_we && st_ff == ST_STANDBY) begin
      nv_mem[i_nv_addr] <= i_nv_wdata;
    end
    if (st_ff == ST_CFGCOPY) begin
      sram_ff[cnt_ff[3:0]] <= nv_mem[cnt_ff[3:0]];
    end else if (i_sram_we && st_ff != ST_OFF && st_ff != ST_PWRUP) begin
      sram_ff[i_sram_addr] <= i_sram_wdata;
    end
    if (buf_push) begin
      buf_mem[wr_ff[4:0]] <= i_byte;
    end
  end

  // wake pins biased in every state
  assign o_wake_bias = bias_ff;
  assign o_nv_we_refused = refused_ff;
  assign o_sram_rdata = rdat_ff;
  assign o_buf_rdata = bdat_ff;
  assign o_buf_empty = empty_ff;
  assign o_notify_port_bit = notify_ff;
  assign o_digital_supply_domain = outs_ff[6];
  assign o_analog_supply_domain = outs_ff[5];
  assign o_antenna_switch_supply = outs_ff[4];
  assign o_crystal_oscillator = outs_ff[3];
  assign o_slow_rc_oscillator = outs_ff[2];
  assign o_fast_rc_oscillator = outs_ff[1];
  assign o_blocks_prog = outs_ff[0];
  assign o_cpu_sleep = slp_ff;
  assign o_channel = ch_ff;
  assign o_state = st_ff;
endmodule : rxmc_top
`default_nettype wire

// [inc/rxmc_pkg.sv]
/*
  package for the receiver operating mode controller: state enum,
  command codes, start-up selections, timing counts and sizes.
  assumes a single 25 MHz clock and synchronous active-high reset.
*/
`default_nettype none
package rxmc_pkg;
  // system clock rate in kHz
  localparam int CLK_KHZ = 25000;
  // power-on sequence time in microseconds, and its cycle count
  localparam int PWRUP_US = 100;
  localparam int PWRUP_CYC = (PWRUP_US * CLK_KHZ + 999) / 1000;
  // config copy: number of words moved from nonvolatile store to sram
  localparam int CFG_WORDS = 16;
  // slow rc rate in kHz, and the divider that makes its enable pulse
  localparam int SRC_KHZ = 125;
  localparam int SRC_DIV = CLK_KHZ / SRC_KHZ;
  // receive buffer depth in bytes
  localparam int RXBUF_DEPTH = 32;
  // number of scan channels
  localparam int NUM_CH = 5;
  // active period length in slow-rc ticks
  localparam logic [7:0] SCAN_ACTIVE_TICKS = 8'h10;
  // tune and check timer load in cycles; each tune lasts this many cycles plus one
  localparam logic [7:0] TUNE_CYC = 8'h40;

  // host command codes
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_IDLE = 3'h1;
  localparam logic [2:0] CMD_RX = 3'h2;
  localparam logic [2:0] CMD_SCAN = 3'h3;
  localparam logic [2:0] CMD_TUNE = 3'h4;
  localparam logic [2:0] CMD_OFF = 3'h5;

  // stored start-up selection
  localparam logic [1:0] START_STANDBY = 2'h0;
  localparam logic [1:0] START_RX = 2'h1;
  localparam logic [1:0] START_SCAN = 2'h2;

  // processor sleep encodings
  localparam logic [1:0] SLP_ACTIVE = 2'h0;

  typedef enum logic [3:0] {
    ST_OFF, ST_PWRUP, ST_CFGCOPY, ST_INITTUNE, ST_STANDBY, ST_RXPROG,
    ST_RX, ST_SCAN_ACT, ST_SCAN_SLEEP, ST_TUNE
  } rxmc_state_e;
endpackage : rxmc_pkg
`default_nettype wire

// [inc/rxmc_tick_if.sv]
/*
  interface carrying the slow-rc tick from the divider to the sequencer.
  assumes both ends share the system clock.
*/
`default_nettype none
interface rxmc_tick_if;
  logic run; // divider enabled
  logic tick; // one-cycle slow tick
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface : rxmc_tick_if
`default_nettype wire

// [tb/rxmc_chk.sv]
/*
  checker for the mode controller top ports.
  assumes it is bound into every rxmc_top instance.
*/
`default_nettype none
module rxmc_chk
  import rxmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wake_request_high_pin,
  input wire logic [5:0] i_wake_request_low_pins_n,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd,
  input wire logic i_nv_we,
  input wire logic o_nv_we_refused,
  input wire logic o_buf_empty,
  input wire logic o_notify_port_bit,
  input wire logic o_digital_supply_domain,
  input wire logic o_analog_supply_domain,
  input wire logic o_crystal_oscillator,
  input wire logic o_slow_rc_oscillator,
  input wire logic o_fast_rc_oscillator,
  input wire logic o_blocks_prog,
  input wire logic [2:0] o_channel,
  input wire logic [3:0] o_state,
  input wire logic o_wake_bias
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wake; // any wake pin active
  logic [11:0] up_cnt_ff; // cycles spent in power-up
  logic [11:0] nxt_up_cnt;
  assign wake = i_wake_request_high_pin | ~&i_wake_request_low_pins_n;
  // count power-up cycles, a long span no repetition can hold
  always_comb begin
    nxt_up_cnt = (o_state == 4'h1) ? up_cnt_ff + 12'h001 : 12'h000;
  end
  always_ff @(posedge i_clk) begin
    up_cnt_ff <= i_reset ? 12'h000 : nxt_up_cnt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_off_pwr;
    o_state == 4'h0 |-> !(o_digital_supply_domain | o_analog_supply_domain
      | o_crystal_oscillator | o_slow_rc_oscillator | o_fast_rc_oscillator);
  endproperty
  a_off_pwr: assert property (p_off_pwr) else $error("power on in off");
  property p_bias;
    o_wake_bias;
  endproperty
  a_bias: assert property (p_bias) else $error("wake bias lost");
  property p_off_cmd;
    o_state == 4'h0 && !wake |=> o_state == 4'h0;
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("left off alone");
  property p_wake;
    o_state == 4'h0 && wake |=> o_state == 4'h1;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_up_len;
    $fell(o_state == 4'h1) |-> up_cnt_ff == PWRUP_CYC;
  endproperty
  a_up_len: assert property (p_up_len) else $error("power-up length");
  property p_refuse;
    i_nv_we |=> o_nv_we_refused == ($past(o_state) != 4'h4);
  endproperty
  a_refuse: assert property (p_refuse) else $error("nv refusal wrong");
  property p_rx_cmd;
    o_state == 4'h4 && i_cmd_valid && i_cmd == CMD_RX
      |=> o_state == 4'h5 && o_blocks_prog ##1 o_state == 4'h6;
  endproperty
  a_rx_cmd: assert property (p_rx_cmd) else $error("rx start order");
  property p_rx_pwr;
    o_state == 4'h6 |-> o_analog_supply_domain && o_crystal_oscillator
      && o_slow_rc_oscillator && !o_fast_rc_oscillator;
  endproperty
  a_rx_pwr: assert property (p_rx_pwr) else $error("rx supplies");
  property p_sleep_pwr;
    o_state == 4'h8 |-> o_slow_rc_oscillator && !o_fast_rc_oscillator
      && o_analog_supply_domain == o_crystal_oscillator;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep supplies");
  property p_chan;
    o_channel < 3'h5;
  endproperty
  a_chan: assert property (p_chan) else $error("channel range");
  property p_notify;
    $fell(o_notify_port_bit) |-> o_buf_empty;
  endproperty
  a_notify: assert property (p_notify) else $error("notify fell early");
  c_rx: cover property (o_state == 4'h6 && o_notify_port_bit);
  c_sleep: cover property (o_state == 4'h8);
  c_tune: cover property (o_state == 4'h9);
  c_refused: cover property (o_nv_we_refused);
endmodule : rxmc_chk
bind rxmc_top rxmc_chk chk (.i_clk, .i_reset, .i_wake_request_high_pin,
  .i_wake_request_low_pins_n, .i_cmd_valid, .i_cmd, .i_nv_we,
  .o_nv_we_refused, .o_buf_empty, .o_notify_port_bit,
  .o_digital_supply_domain, .o_analog_supply_domain, .o_crystal_oscillator,
  .o_slow_rc_oscillator, .o_fast_rc_oscillator, .o_blocks_prog, .o_channel,
  .o_state, .o_wake_bias);
`default_nettype wire

// [tb/rxmc_host.sv]
/*
  host model: drains the receive buffer once notified.
  assumes rdata holds the popped byte one cycle after the pop.
*/
`default_nettype none
module rxmc_host
(
  input wire logic i_clk,
  input wire logic i_notify,
  input wire logic i_empty,
  input wire logic [7:0] i_rdata,
  output var logic o_rd = 1'b0,
  output var logic o_got = 1'b0,
  output var logic [7:0] o_byte = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend = 1'b0; // pop issued, byte due
  always @(negedge i_clk) begin
    o_got <= 1'b0;
    if (o_rd) begin
      o_rd <= 1'b0;
      pend <= 1'b1;
    end else if (pend) begin
      pend <= 1'b0;
      o_got <= 1'b1;
      o_byte <= i_rdata;
    end else if (i_notify && !i_empty) begin
      o_rd <= 1'b1;
    end
  end
endmodule : rxmc_host
`default_nettype wire

// [tb/rxmc_top_tb.sv]
/*
  self-checking bench for rxmc_top with a host model.
  assumes a 25 MHz clock and inputs driven at the falling edge.
*/
`default_nettype none
module rxmc_top_tb
  import rxmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wake_request_high_pin = 1'b0;
  logic [5:0] i_wake_request_low_pins_n = 6'h3F;
  logic i_cmd_valid = 1'b0, i_nv_we = 1'b0, i_sram_we = 1'b0;
  logic [2:0] i_cmd = 3'h0;
  logic [3:0] i_nv_addr = 4'h0, i_sram_addr = 4'h0;
  logic [7:0] i_nv_wdata = 8'h00, i_sram_wdata = 8'h00, i_byte = 8'h00;
  logic i_sram_re = 1'b0, i_buf_rd, i_byte_valid = 1'b0;
  logic i_preamble_ok = 1'b0, i_checks_ok = 1'b0;
  logic o_nv_we_refused, o_buf_empty, o_notify_port_bit, o_blocks_prog;
  logic o_digital_supply_domain, o_analog_supply_domain, o_wake_bias;
  logic o_antenna_switch_supply, o_crystal_oscillator, got;
  logic o_slow_rc_oscillator, o_fast_rc_oscillator;
  logic [7:0] o_sram_rdata, o_buf_rdata, got_b, d, w0, nb, rb;
  logic [1:0] o_cpu_sleep;
  logic [2:0] o_channel;
  logic [3:0] o_state;
  logic [7:0] exp_q[$]; // bytes the host should get
  int n_mismatch = 0, total_checks = 0;
  always #20 i_clk = ~i_clk;
  rxmc_top dut (.i_clk, .i_reset, .i_wake_request_high_pin,
    .i_wake_request_low_pins_n, .i_cmd_valid, .i_cmd, .i_nv_we, .i_nv_addr,
    .i_nv_wdata, .i_sram_we, .i_sram_re, .i_sram_addr, .i_sram_wdata,
    .i_buf_rd, .i_preamble_ok, .i_checks_ok, .i_byte_valid, .i_byte,
    .o_nv_we_refused, .o_sram_rdata, .o_buf_rdata, .o_buf_empty,
    .o_notify_port_bit, .o_digital_supply_domain, .o_analog_supply_domain,
    .o_antenna_switch_supply, .o_crystal_oscillator, .o_slow_rc_oscillator,
    .o_fast_rc_oscillator, .o_cpu_sleep, .o_blocks_prog, .o_channel,
    .o_state, .o_wake_bias);
  rxmc_host host (.i_clk, .i_notify(o_notify_port_bit), .i_empty(o_buf_empty),
    .i_rdata(o_buf_rdata), .o_rd(i_buf_rd), .o_got(got), .o_byte(got_b));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic cmd(input logic [2:0] c);
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd = c;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask : cmd
  task automatic nvw(input logic [3:0] a, input logic [7:0] v);
    @(negedge i_clk);
    i_nv_we = 1'b1;
    i_nv_addr = a;
    i_nv_wdata = v;
    @(negedge i_clk);
    i_nv_we = 1'b0;
  endtask : nvw
  task automatic sram(input logic we, input logic [3:0] a, inout logic [7:0] v);
    @(negedge i_clk);
    i_sram_we = we;
    i_sram_re = !we;
    i_sram_addr = a;
    i_sram_wdata = v;
    @(negedge i_clk);
    {i_sram_we, i_sram_re} = 2'b00;
    if (!we) v = o_sram_rdata;
  endtask : sram
  task automatic push(input logic [7:0] b);
    @(negedge i_clk);
    i_byte_valid = 1'b1;
    i_byte = b;
    @(negedge i_clk);
    i_byte_valid = 1'b0;
  endtask : push
  task automatic wait_st(input logic [3:0] s, input int lim);
    for (int k = 0; k < lim && o_state !== s; k++) @(negedge i_clk);
    chk("state", o_state, s);
  endtask : wait_st
  task automatic wake(input logic hp);
    @(negedge i_clk);
    if (hp) i_wake_request_high_pin = 1'b1;
    else i_wake_request_low_pins_n[$urandom % 6] = 1'b0;
    @(negedge i_clk);
    i_wake_request_high_pin = 1'b0;
    i_wake_request_low_pins_n = 6'h3F;
    chk("wake", o_state, 4'h1);
  endtask : wake
  // host side compares every drained byte in order
  always @(posedge i_clk) if (got === 1'b1 && exp_q.size() > 0)
    chk("rx byte", got_b, exp_q.pop_front());
  initial begin
    #2_400_000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hC2C4C211));
    repeat (10) @(negedge i_clk);
    i_reset = 1'b0;
    cmd(3'($urandom % 5 + 1));
    chk("off", o_state, 4'h0);
    chk("digital_supply_domain", o_digital_supply_domain, 1'b0);
    wake(1'b0);
    wait_st(4'h4, 3000);
    w0 = {1'b0, 2'($urandom % 3 + 1), 2'b00, 1'($urandom), 2'b00};
    nb = 8'($urandom % 4 + 2);
    nvw(4'h0, w0);
    chk("nv ok", o_nv_we_refused, 1'b0);
    nvw(4'h1, 8'h02);
    nvw(4'h2, nb);
    cmd(CMD_OFF);
    chk("to off", o_state, 4'h0);
    wake(1'b1);
    wait_st(4'h4, 3000);
    sram(1'b0, 4'h2, d);
    chk("shadow", d, nb);
    chk("sleep", o_cpu_sleep, w0[6:5]);
    chk("xtal", o_crystal_oscillator, w0[2]);
    chk("src", o_slow_rc_oscillator, 1'b1);
    chk("spdt", o_antenna_switch_supply, 1'b0);
    d = 8'($urandom);
    w0[7] = 1'b0;
    sram(1'b1, 4'hF, d);
    sram(1'b0, 4'hF, rb);
    chk("sram", rb, d);
    cmd(CMD_RX);
    chk("prog", o_blocks_prog, 1'b1);
    wait_st(4'h6, 4);
    nvw(4'h3, 8'hAA);
    chk("nv refused", o_nv_we_refused, 1'b1);
    i_preamble_ok = 1'b1;
    push(8'($urandom));
    chk("bad byte", o_buf_empty, 1'b1);
    i_checks_ok = 1'b1;
    repeat (nb) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      push(d);
    end
    {i_preamble_ok, i_checks_ok} = 2'b00;
    for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge i_clk);
    chk("drained", 8'(exp_q.size()), 8'h00);
    repeat (3) @(negedge i_clk);
    chk("notify", o_notify_port_bit, 1'b0);
    cmd(CMD_IDLE);
    chk("idle", o_state, 4'h4);
    cmd(CMD_SCAN);
    chk("scan", o_state, 4'h7);
    wait_st(4'h8, 20000);
    wait_st(4'h7, 1000);
    cmd(CMD_IDLE);
    cmd(CMD_TUNE);
    chk("tune", o_state, 4'h9);
    wait_st(4'h4, 200);
    nvw(4'h0, {w0[7:4], 1'b1, w0[2], 2'b01});
    cmd(CMD_OFF);
    wake(1'b0);
    wait_st(4'h3, 3000);
    wait_st(4'h6, 200);
    // start-up scan with periodic tune, then a hit served, then scan sleep and tune
    cmd(CMD_IDLE);
    chk("idle2", o_state, 4'h4);
    nvw(4'h0, {w0[7:5], 1'b1, 1'b0, w0[2], 2'b10});
    cmd(CMD_OFF);
    wake(1'b1);
    wait_st(4'h7, 3000);
    {i_preamble_ok, i_checks_ok} = 2'b11;
    wait_st(4'h6, 4);
    repeat (nb) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      push(d);
    end
    {i_preamble_ok, i_checks_ok} = 2'b00;
    wait_st(4'h8, 50);
    wait_st(4'h9, 1000);
    chk("drained2", 8'(exp_q.size()), 8'h00);
    wait_st(4'h7, 200);
    end_sim();
  end
endmodule : rxmc_top_tb
`default_nettype wire
